//--- exc_arbiter.sv
`timescale 1ns/1ps
module exc_arbiter
	import exc_arb_pkg::*;
#(
	parameter int LONG_DELAY  = LONG_RECOVERY,
	parameter int SHORT_DELAY = SHORT_RECOVERY
) (
	// Clock and internal reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// AXI4-Lite slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Request sources, bit 0 is flag 1
	input  wire logic [NUM_IRQ-1:0]   irq_req,
	input  wire logic [NUM_IRQ-1:0]   irq_enable,
	input  wire logic                 break_req,
	input  wire logic                 ext_reset_pin,
	input  wire logic                 int_reset_req,
	// CPU core
	input  wire logic                 instr_done,
	input  wire logic                 mask_bit,
	input  wire logic                 soft_trap_instr,
	input  wire logic                 return_from_trap_instr,
	input  wire logic                 stop_instr,
	input  wire logic                 vector_taken,
	output exc_out_s                  exc,
	output logic                      restore_regs,
	output logic                      cpu_clock_en
);
	arb_state_e         state_r, state_nxt;
	logic [CNT_W-1:0]   count_r, count_nxt;
	logic               short_sel_r;
	logic               boundary_r;
	exc_out_s           exc_r, exc_nxt;
	logic               restore_r;

	// Priority encoder: lowest flag index wins
	function automatic logic [4:0] pick_irq(input logic [NUM_IRQ-1:0] p);
		logic [4:0] c;
		c = 5'h00;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (p[i]) begin
				c = CODE_IRQ_BASE + 5'(i);
			end
		end
		return c;
	endfunction : pick_irq

	// Arbitration
	wire                 any_reset   = int_reset_req | ext_reset_pin;
	wire [NUM_IRQ-1:0]   hw_pending  = irq_req & irq_enable;
	wire                 hw_take     = !mask_bit && (|hw_pending); // R10
	wire                 sw_take     = soft_trap_instr | break_req; // R14 R21
	wire                 at_boundary = instr_done | boundary_r; // R09
	wire [4:0]           hw_code     = pick_irq(hw_pending); // R11 R18
	wire [4:0]           win_code    = sw_take ? CODE_SOFT_TRAP : hw_code; // R18
	wire                 wake        = (|hw_pending) | break_req | ext_reset_pin;
	wire [CNT_W:0]       delay_cnt   = short_sel_r ? (CNT_W+1)'(SHORT_DELAY) : (CNT_W+1)'(LONG_DELAY); // R02
	wire                 recov_done  = ({1'b0, count_r} == delay_cnt - (CNT_W+1)'(1));

	always_comb begin
		state_nxt = state_r;
		exc_nxt   = exc_r;
		exc_nxt.start    = 1'b0;
		exc_nxt.set_mask = 1'b0;
		count_nxt = count_r + CNT_W'(1); // R04 R23
		unique case (state_r)
			ST_RUN: begin
				if (stop_instr) begin
					state_nxt = ST_STOPPED;
					count_nxt = '0; // R01
				end else if (at_boundary && (sw_take || hw_take)) begin
					state_nxt            = ST_LATCHED; // R07
					exc_nxt.start        = 1'b1; // R05
					exc_nxt.set_mask     = 1'b1; // R05
					exc_nxt.pc_minus_one = !sw_take; // R15
					exc_nxt.code         = win_code; // R07
					exc_nxt.addr         = vector_of(win_code);
				end
			end
			ST_STOPPED: begin
				count_nxt = '0;
				if (wake) begin
					state_nxt = ST_RECOVER; // R02
				end
			end
			ST_RECOVER: begin
				if (recov_done) begin
					state_nxt = ST_RUN; // R24
				end
			end
			ST_LATCHED: begin
				if (vector_taken) begin
					state_nxt = ST_RUN; // R08 R12
				end
			end
		endcase
		// Reset sources bypass arbitration
		if (any_reset && state_r != ST_STOPPED && state_r != ST_RECOVER) begin
			state_nxt            = ST_LATCHED; // R19
			exc_nxt.start        = 1'b1;
			exc_nxt.set_mask     = 1'b1;
			exc_nxt.pc_minus_one = 1'b0;
			exc_nxt.code         = CODE_RESET;
			exc_nxt.addr         = vector_of(CODE_RESET);
		end
	end

	// Pin reset is a request, not a counter reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r    <= ST_RUN;
			count_r    <= '0;
			exc_r      <= '0;
			boundary_r <= 1'b0;
			restore_r  <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			count_r    <= count_nxt; // R03
			exc_r      <= exc_nxt;
			boundary_r <= (state_r == ST_RECOVER) && recov_done; // R24
			restore_r  <= return_from_trap_instr; // R06
		end
	end

	// Index high register is never part of the stack frame
	assign exc          = exc_r; // R13
	assign restore_regs = restore_r;
	assign cpu_clock_en = (state_r == ST_RUN) || (state_r == ST_LATCHED);

	// Status views of raw request presence
	logic [7:0] stat_low, stat_mid, stat_high;
	genvar g;
	generate
		for (g = 0; g < 6; g++) begin : g_low
			assign stat_low[g+2] = irq_req[g]; // R16
		end
		for (g = 0; g < 8; g++) begin : g_mid
			assign stat_mid[g] = irq_req[g+6]; // R16
		end
		for (g = 0; g < 7; g++) begin : g_high
			assign stat_high[g] = irq_req[g+14]; // R17
		end
	endgenerate
	assign stat_low[1:0] = 2'b00; // R16
	assign stat_high[7]  = 1'b0;

	// AXI4-Lite write path
	logic       aw_held_r, w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic       bvalid_r;
	logic [1:0] bresp_r;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFS_STATUS_LOW) || (a == OFS_STATUS_MID) || (a == OFS_STATUS_HIGH) ||
			(a == OFS_CONTROL) || (a == OFS_RECOVERY);
	endfunction : mapped

	wire aw_fire  = s_axi_awvalid && s_axi_awready;
	wire w_fire   = s_axi_wvalid && s_axi_wready;
	wire have_aw  = aw_held_r || aw_fire;
	wire have_w   = w_held_r || w_fire;
	wire [7:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
	wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
	wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
	wire wr_do    = have_aw && have_w && !bvalid_r;
	wire ctrl_wr  = wr_do && (wr_addr == OFS_CONTROL) && wr_strb[0];

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready  = !w_held_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r   <= 1'b0;
			w_held_r    <= 1'b0;
			aw_addr_r   <= '0;
			w_data_r    <= '0;
			w_strb_r    <= '0;
			bvalid_r    <= 1'b0;
			bresp_r     <= RESP_OKAY;
			short_sel_r <= CTRL_RESET;
		end else begin
			if (aw_fire) begin
				aw_addr_r <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			aw_held_r <= have_aw && !wr_do;
			w_held_r  <= have_w && !wr_do;
			if (wr_do) begin
				bvalid_r <= 1'b1;
				bresp_r  <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR; // R25
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
			// Status writes fall through: flags are live views
			if (ctrl_wr) begin
				short_sel_r <= wr_data[CTRL_SHORT_BIT]; // R02
			end
		end
	end

	// AXI4-Lite read path
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic [31:0] rd_mux;

	always_comb begin
		unique case (s_axi_araddr)
			OFS_STATUS_LOW:  rd_mux = {24'h000000, stat_low};
			OFS_STATUS_MID:  rd_mux = {24'h000000, stat_mid};
			OFS_STATUS_HIGH: rd_mux = {24'h000000, stat_high};
			OFS_CONTROL:     rd_mux = {31'h00000000, short_sel_r};
			OFS_RECOVERY:    rd_mux = {19'h00000, count_r};
			default:         rd_mux = 32'h00000000;
		endcase
	end

	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end
endmodule : exc_arbiter

//--- exc_arb_pkg.sv
// Behaviour
// (R01) Stop instruction clears recovery counter
// (R02) Wake from stop: 32 or 4096 cycle delay
// (R03) External reset pin leaves counter unchanged
// (R04) Counter free-runs after any reset
// (R05) Entry stacks registers and sets mask
// (R06) Return instruction restores stacked registers
// (R07) Latch and arbitrate, give vector code
// (R08) Latched request holds until serviced
// (R09) Hardware request waits for instruction end
// (R10) Take only if unmasked and enabled
// (R11) Highest priority pending request goes first
// (R12) Still-pending request served before program resumes
// (R13) Index high register is never stacked
// (R14) Soft trap ignores the mask bit
// (R15) Soft trap stacks PC, hardware PC-1
// (R16) Flags 1..14 show request; low bits zero
// (R17) Flags 15..21 show request presence
// (R18) Priority rises with vector address
// (R19) Resets highest, taken without arbitration; not taken while in ST_STOPPED or ST_RECOVER
// (R20) Break module asserts break request
// (R21) Break forces the soft trap vector
// (R22) Crystal users keep short recovery cleared
// (R23) Thirteen-bit recovery counter
// (R24) Stacking after wake waits for recovery
// (R25) Status register writes are ignored
package exc_arb_pkg;
	localparam int          NUM_IRQ          = 21;
	localparam int          CNT_W            = 13;
	localparam int          CODE_W           = 5;
	// Register byte offsets
	localparam logic [7:0]  OFS_STATUS_LOW   = 8'h00;
	localparam logic [7:0]  OFS_STATUS_MID   = 8'h04;
	localparam logic [7:0]  OFS_STATUS_HIGH  = 8'h08;
	localparam logic [7:0]  OFS_CONTROL      = 8'h0C;
	localparam logic [7:0]  OFS_RECOVERY     = 8'h10;
	// Control register fields
	localparam int          CTRL_SHORT_BIT   = 0;
	localparam logic        CTRL_RESET       = 1'b0;
	// Recovery delays in crystal clock cycles
	localparam int          LONG_RECOVERY    = 4096;
	localparam int          SHORT_RECOVERY   = 32;
	// Vector codes; address = TOP_VECTOR - 2 * code
	localparam logic [4:0]  CODE_RESET       = 5'h00;
	localparam logic [4:0]  CODE_SOFT_TRAP   = 5'h01;
	localparam logic [4:0]  CODE_IRQ_BASE    = 5'h02;
	localparam logic [15:0] TOP_VECTOR       = 16'hFFFE;
	localparam logic [1:0]  RESP_OKAY        = 2'b00;
	localparam logic [1:0]  RESP_SLVERR      = 2'b10;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_STOPPED,
		ST_RECOVER,
		ST_LATCHED
	} arb_state_e;

	typedef struct packed {
		logic        start;
		logic        set_mask;
		logic        pc_minus_one;
		logic [4:0]  code;
		logic [15:0] addr;
	} exc_out_s;

	function automatic logic [15:0] vector_of(input logic [4:0] code);
		vector_of = TOP_VECTOR - {10'h000, code, 1'b0};
	endfunction : vector_of
endpackage : exc_arb_pkg

//--- exc_arbiter_asserts.sv
`timescale 1ns/1ps
module exc_arbiter_asserts
	import exc_arb_pkg::*;
(
	// Clock and reset
	input wire logic     aclk,
	input wire logic     aresetn,
	// Core and sources
	input wire logic     instr_done,
	input wire logic     mask_bit,
	input wire logic     soft_trap_instr,
	input wire logic     return_from_trap_instr,
	input wire logic     stop_instr,
	input wire logic     vector_taken,
	input wire logic     break_req,
	input wire logic     ext_reset_pin,
	input wire logic     int_reset_req,
	// Watched outputs
	input wire exc_out_s exc,
	input wire logic     restore_regs,
	input wire logic     cpu_clock_en
);
	logic latched_r;
	wire  rst_any = ext_reset_pin | int_reset_req;
	// Mirrors the latch so preemption can be judged
	always_ff @(posedge aclk) begin
		if (!aresetn || vector_taken)
			latched_r <= 1'b0;
		else if (exc.start)
			latched_r <= 1'b1;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_start_pulse: assert property (exc.start && !rst_any |=> !exc.start)
		else $error("start held too long");
	a_mask_set: assert property (exc.start |-> exc.set_mask)
		else $error("mask not set at entry");
	a_vector_addr: assert property (exc.start |-> exc.addr == TOP_VECTOR - {10'h000, exc.code, 1'b0})
		else $error("vector address wrong");
	a_pc_adjust: assert property (exc.start |-> exc.pc_minus_one == (exc.code >= CODE_IRQ_BASE))
		else $error("stacked pc kind wrong");
	a_restore_next: assert property (return_from_trap_instr |=> restore_regs)
		else $error("no restore after return");
	a_no_preempt: assert property (latched_r && !vector_taken && !rst_any |=> !exc.start)
		else $error("latched request preempted");
	a_masked_idle: assert property (instr_done && mask_bit && !soft_trap_instr && !break_req && !rst_any
		&& cpu_clock_en && $past(cpu_clock_en) |=> !exc.start)
		else $error("masked request taken");
	a_soft_trap: assert property (instr_done && soft_trap_instr && cpu_clock_en && !latched_r && !exc.start
		&& !rst_any && !stop_instr |=> exc.start && exc.code == CODE_SOFT_TRAP)
		else $error("soft trap not taken");
	a_reset_take: assert property (int_reset_req && cpu_clock_en |=> exc.start && exc.code == CODE_RESET)
		else $error("reset not taken");
	a_stop_gate: assert property (stop_instr && cpu_clock_en && !latched_r && !exc.start && !rst_any
		|=> !cpu_clock_en)
		else $error("clock not stopped");
	c_soft: cover property (exc.start && exc.code == CODE_SOFT_TRAP);
	c_restore: cover property (restore_regs);
	c_wake: cover property ($rose(cpu_clock_en));
endmodule : exc_arbiter_asserts
bind exc_arbiter exc_arbiter_asserts chk_u (.*);

//--- cpu_model.sv
`timescale 1ns/1ps
module cpu_model
	import exc_arb_pkg::*;
(
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Exception interface
	input wire exc_out_s   exc,
	input wire logic [1:0] lag,
	output logic           vector_taken
);
	logic [1:0] wait_r;
	logic       busy_r;
	// Stacking takes a variable time before the vector fetch
	always_ff @(posedge aclk) begin
		vector_taken <= 1'b0;
		if (!aresetn) begin
			busy_r <= 1'b0;
		end else if (exc.start) begin
			busy_r <= 1'b1;
			wait_r <= lag;
		end else if (busy_r && wait_r == 2'h0) begin
			busy_r       <= 1'b0;
			vector_taken <= 1'b1;
		end else if (busy_r) begin
			wait_r <= wait_r - 2'h1;
		end
	end
endmodule : cpu_model

//--- exc_arbiter_test.sv
`timescale 1ns/1ps
module exc_arbiter_test
	import exc_arb_pkg::*;
;
	localparam int      LONG_T = 64;
	logic               aclk = 0, aresetn = 0;
	logic [7:0]         s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0]        s_axi_wdata = 0, s_axi_rdata, q, d;
	logic [3:0]         s_axi_wstrb = 4'hF;
	logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic               s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]         s_axi_bresp, s_axi_rresp, r, lag = 0;
	logic [NUM_IRQ-1:0] irq_req = 0, irq_enable = 0;
	logic               break_req = 0, ext_reset_pin = 0, int_reset_req = 0, instr_done = 0, mask_bit = 1;
	logic               soft_trap_instr = 0, return_from_trap_instr = 0, stop_instr = 0;
	logic               vector_taken, restore_regs, cpu_clock_en;
	exc_out_s           exc;
	int                 num_errors = 0, cmp_count = 0, k, n;
	exc_arbiter #(.LONG_DELAY(LONG_T)) dut_u (.*);
	cpu_model cpu_u (.*);
	always #50 aclk = ~aclk;
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task results;
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results
	task tmo(input int n, input int lim);
		if (n >= lim) begin
			check(0, 1);
			results();
		end
	endtask : tmo
	task axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		tmo(n, 40);
		rs = s_axi_bresp;
		s_axi_bready <= 0;
	endtask : axw
	task axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		tmo(n, 40);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 0;
	endtask : axr
	function automatic logic [4:0] exp_code(input logic [NUM_IRQ-1:0] p);
		exp_code = 5'h1F;
		for (int i = NUM_IRQ - 1; i >= 0; i--) if (p[i]) exp_code = CODE_IRQ_BASE + 5'(i);
	endfunction : exp_code
	function automatic logic [31:0] status(input logic [NUM_IRQ-1:0] p, input int k);
		case (k)
			0: status = {24'h0, p[5:0], 2'b00};
			1: status = {24'h0, p[13:6]};
			default: status = {25'h0, p[20:14]};
		endcase
	endfunction : status
	task bound(input logic st);
		soft_trap_instr <= st; instr_done <= 1;
		@(posedge aclk);
		soft_trap_instr <= 0; instr_done <= 0;
	endtask : bound
	task wstart(input logic [4:0] c);
		for (n = 0; n < 5000 && exc.start !== 1'b1; n++) @(posedge aclk);
		tmo(n, 5000);
		check(exc.code, c);
		check(exc.addr, TOP_VECTOR - {10'h000, c, 1'b0});
		check(exc.pc_minus_one, c >= CODE_IRQ_BASE);
		for (n = 0; n < 10 && vector_taken !== 1'b1; n++) @(posedge aclk);
		@(posedge aclk);
	endtask : wstart
	initial begin
		void'($urandom(54119));
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		repeat (4) begin
			q = $urandom;
			irq_req <= q[NUM_IRQ-1:0];
			@(posedge aclk);
			for (k = 0; k < 3; k++) begin
				axw(8'(4 * k), $urandom, r);
				check(r, RESP_OKAY);
				axr(8'(4 * k), d, r);
				check(d, status(irq_req, k));
			end
		end
		axr(8'h40, d, r);
		check(r, RESP_SLVERR);
		mask_bit <= 0;
		for (k = 0; k < 6; k++) begin
			q = (k == 0) ? 32'h0010_0000 : ($urandom | 32'h0010_0000);
			d = $urandom | 32'h0010_0000;
			irq_req <= q[20:0]; irq_enable <= d[20:0]; lag <= d[31:30];
			@(posedge aclk);
			bound(0);
			wstart(exp_code(q[20:0] & d[20:0]));
		end
		mask_bit <= 1;
		bound(1);
		wstart(CODE_SOFT_TRAP);
		break_req <= 1;
		bound(0);
		break_req <= 0;
		wstart(CODE_SOFT_TRAP);
		mask_bit <= 0;
		bound(1);
		wstart(CODE_SOFT_TRAP);
		return_from_trap_instr <= 1;
		@(posedge aclk);
		return_from_trap_instr <= 0;
		@(posedge aclk);
		check(restore_regs, 1);
		bound(0);
		wstart(exp_code(irq_req & irq_enable));
		for (k = 0; k < 2; k++) begin
			if (k == 1) axr(OFS_RECOVERY, d, r);
			if (k == 0) int_reset_req <= 1;
			else ext_reset_pin <= 1;
			@(posedge aclk);
			int_reset_req <= 0; ext_reset_pin <= 0;
			wstart(CODE_RESET);
			// Pin reset must not clear the free-running counter
			if (k == 1) begin
				axr(OFS_RECOVERY, q, r);
				check(13'(q - d) >= 13'h003 && 13'(q - d) <= 13'h01E, 1);
			end
		end
		irq_enable <= '1;
		for (k = 0; k < 2; k++) begin
			axw(OFS_CONTROL, 32'(k == 0), r);
			irq_req <= 0; stop_instr <= 1;
			@(posedge aclk);
			stop_instr <= 0;
			repeat (5) @(posedge aclk);
			check(cpu_clock_en, 0);
			irq_req <= 21'h2;
			for (n = 0; n < 5000 && cpu_clock_en !== 1'b1; n++) @(posedge aclk);
			q = k ? LONG_T : SHORT_RECOVERY;
			check(n >= q && n <= q + 2, 1);
			wstart(CODE_IRQ_BASE + 5'h01);
			irq_req <= 0;
		end
		results();
	end
endmodule : exc_arbiter_test
